/* File: logic/spsw_top.v */
// Power switch serial link, reset handling and register slave
`timescale 1ns/1ps
`include "spsw_map.vh"
module spsw_top #(
  parameter FRAME_BITS = 8,
  parameter RING_HALF = `SPSW_RING_HALF_CYC
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Chip pins: resets and suspend
  input wire global_reset_n,
  input wire host_bus_reset_n,
  input wire suspend,
  // Switch clock pin
  input wire switch_clock_in,
  output reg switch_clock_out,
  output reg switch_clock_oe,
  // Switch data pin
  output reg switch_data_out,
  output reg switch_data_oe,
  // Switch latch pin
  input wire switch_latch_in,
  output reg switch_latch_out,
  output reg switch_latch_oe,
  // EEPROM side, same clock domain
  input wire eeprom_scl,
  input wire eeprom_sda_out,
  input wire eeprom_sda_oe,
  output reg eeprom_sda_in,
  output reg eeprom_mode,
  // Multifunction pins
  input wire multifunction_pin_one_in,
  output reg multifunction_pin_one_out,
  output reg multifunction_pin_one_oe,
  output reg multifunction_pin_four_out,
  output reg multifunction_pin_four_oe,
  // Power management event, open drain
  input wire pme_event,
  output reg pme_out,
  output reg pme_oe,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam CW = $clog2(FRAME_BITS + 1);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_LATCH = 3'b100;
  localparam [31:0] SYSCTL_RST = `SPSW_SYSCTL_RESET;

  // ==========================================================
  // Pin synchronisers
  wire [5:0] pins_s;
  spsw_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({multifunction_pin_one_in, switch_latch_in, switch_clock_in,
               suspend, host_bus_reset_n, global_reset_n}),
    .sync_out(pins_s)
  );
  wire global_reset_n_act = ~pins_s[0];
  wire host_bus_reset_n_act = ~pins_s[1];
  wire susp_s = pins_s[2];
  wire sclk_ext = pins_s[3];
  wire latch_s = pins_s[4];
  wire mf1_s = pins_s[5];
  wire hiz = global_reset_n_act | host_bus_reset_n_act;
  wire reg_clear = hiz & ~susp_s;

  // ==========================================================
  // Registers
  reg drive_sel;
  reg pme_en;
  reg [31:0] frame_data;
  reg pend;
  reg [2:0] state;
  reg [FRAME_BITS-1:0] shreg;
  reg [CW-1:0] bit_cnt;
  reg [15:0] ring_cnt;
  reg sclk_prev;
  reg [1:0] strap_cnt;
  reg strap_valid;
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // ==========================================================
  // Ring oscillator divider
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ring_cnt <= 16'h0000;
      switch_clock_out <= 1'b0;
    end else if (ring_cnt == RING_HALF[15:0] - 16'h0001) begin
      ring_cnt <= 16'h0000;
      switch_clock_out <= ~switch_clock_out;
    end else begin
      ring_cnt <= ring_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Switch clock edges
  wire sclk_lvl = drive_sel ? switch_clock_out : sclk_ext;
  wire sclk_fall = sclk_prev & ~sclk_lvl;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_lvl;
    end
  end

  // ==========================================================
  // Bus write path
  wire wr_go = aw_hold & w_hold & ~s_axi_bvalid;
  wire wr_sys = aw_addr[7:2] == `SPSW_SYSCTL_ADDR >> 2;
  wire wr_frm = aw_addr[7:2] == `SPSW_FRAME_ADDR >> 2;
  wire wr_sta = aw_addr[7:2] == `SPSW_STATUS_ADDR >> 2;
  wire [31:0] sys_rd;
  wire [31:0] sta_rd;
  wire [31:0] frm_mrg;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign frm_mrg[8*g+7:8*g] = w_strb[g] ? w_data[8*g+7:8*g]
                                            : frame_data[8*g+7:8*g];
    end
  endgenerate
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPSW_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready;
      s_axi_wready <= ~w_hold & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sys | wr_frm | wr_sta) ? `SPSW_RESP_OKAY
                                                  : `SPSW_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control registers and serial frame engine
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_sel <= 1'b0;
      pme_en <= 1'b0;
      frame_data <= `SPSW_FRAME_RESET;
      pend <= 1'b0;
      state <= ST_IDLE;
      shreg <= {FRAME_BITS{1'b0}};
      bit_cnt <= {CW{1'b0}};
      switch_data_out <= 1'b0;
      switch_latch_out <= 1'b0;
    end else if (reg_clear) begin
      drive_sel <= SYSCTL_RST[`SPSW_DRVSEL_BIT];
      if (global_reset_n_act) begin
        pme_en <= SYSCTL_RST[`SPSW_PMEEN_BIT];
      end
      frame_data <= `SPSW_FRAME_RESET;
      pend <= 1'b0;
      state <= ST_IDLE;
      shreg <= {FRAME_BITS{1'b0}};
      bit_cnt <= {CW{1'b0}};
      switch_data_out <= 1'b0;
      switch_latch_out <= 1'b0;
    end else begin
      if (wr_go & wr_sys & w_strb[`SPSW_DRVSEL_BIT/8]) begin
        drive_sel <= w_data[`SPSW_DRVSEL_BIT];
      end
      if (wr_go & wr_sys & w_strb[`SPSW_PMEEN_BIT/8]) begin
        pme_en <= w_data[`SPSW_PMEEN_BIT];
      end
      if (wr_go & wr_frm) begin
        frame_data <= frm_mrg;
      end
      case (state)
        ST_IDLE: begin
          if (pend) begin
            pend <= 1'b0;
            shreg <= frame_data[FRAME_BITS-1:0];
            bit_cnt <= {CW{1'b0}};
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sclk_fall) begin
            if (bit_cnt == FRAME_BITS[CW-1:0]) begin
              switch_latch_out <= 1'b1;
              state <= ST_LATCH;
            end else begin
              switch_data_out <= shreg[FRAME_BITS-1];
              shreg <= shreg << 1;
              bit_cnt <= bit_cnt + {{(CW-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_LATCH: begin
          if (sclk_fall) begin
            switch_latch_out <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // A new request in the cycle the old one is taken still counts
      if (wr_go & wr_frm) begin
        pend <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Latch strap capture after reset release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt <= 2'h0;
      strap_valid <= 1'b0;
      eeprom_mode <= 1'b0;
    end else if (reg_clear) begin
      strap_cnt <= 2'h0;
      strap_valid <= 1'b0;
      eeprom_mode <= 1'b0;
    end else if (!strap_valid) begin
      if (strap_cnt == `SPSW_STRAP_SETTLE) begin
        strap_valid <= 1'b1;
        eeprom_mode <= ~latch_s;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // ==========================================================
  // Pin drivers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_clock_oe <= 1'b0;
      switch_data_oe <= 1'b0;
      switch_latch_oe <= 1'b0;
      eeprom_sda_in <= 1'b1;
      multifunction_pin_one_out <= 1'b0;
      multifunction_pin_one_oe <= 1'b0;
      multifunction_pin_four_out <= 1'b0;
      multifunction_pin_four_oe <= 1'b0;
      pme_out <= 1'b0;
      pme_oe <= 1'b0;
    end else begin
      switch_clock_oe <= drive_sel & ~hiz;
      switch_data_oe <= ~hiz;
      switch_latch_oe <= strap_valid & ~hiz;
      eeprom_sda_in <= mf1_s;
      multifunction_pin_one_out <= eeprom_sda_out;
      multifunction_pin_one_oe <= eeprom_mode & eeprom_sda_oe & ~hiz;
      multifunction_pin_four_out <= eeprom_scl;
      multifunction_pin_four_oe <= eeprom_mode & ~hiz;
      pme_out <= 1'b0;
      pme_oe <= pme_en & pme_event & ~global_reset_n_act
                & ~(susp_s & host_bus_reset_n_act);
    end
  end

  // ==========================================================
  // Bus read path
  assign sys_rd = ({31'h0, drive_sel} << `SPSW_DRVSEL_BIT)
                | ({31'h0, pme_en} << `SPSW_PMEEN_BIT);
  assign sta_rd = ({31'h0, ~state[0]} << `SPSW_ST_BUSY_BIT)
                | ({31'h0, pend} << `SPSW_ST_PEND_BIT)
                | ({31'h0, eeprom_mode} << `SPSW_ST_EEPROM_BIT)
                | ({31'h0, strap_valid} << `SPSW_ST_STRAP_BIT)
                | ({31'h0, sclk_lvl} << `SPSW_ST_SCLK_BIT);
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SPSW_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SPSW_RESP_OKAY;
        if (ar_idx == `SPSW_SYSCTL_ADDR >> 2) begin
          s_axi_rdata <= sys_rd;
        end else if (ar_idx == `SPSW_FRAME_ADDR >> 2) begin
          s_axi_rdata <= frame_data;
        end else if (ar_idx == `SPSW_STATUS_ADDR >> 2) begin
          s_axi_rdata <= sta_rd;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SPSW_RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // spsw_top

/* File: logic/spsw_map.vh */
// Register map, field positions, reset values and timing counts
`ifndef SPSW_MAP_VH
`define SPSW_MAP_VH
// ==========================================================
// Register byte addresses
`define SPSW_SYSCTL_ADDR 8'h80
`define SPSW_FRAME_ADDR 8'h84
`define SPSW_STATUS_ADDR 8'h88
// ==========================================================
// System control fields
`define SPSW_DRVSEL_BIT 27
`define SPSW_PMEEN_BIT 8
`define SPSW_SYSCTL_RESET 32'h00000000
`define SPSW_FRAME_RESET 32'h00000000
// ==========================================================
// Status fields
`define SPSW_ST_BUSY_BIT 0
`define SPSW_ST_PEND_BIT 1
`define SPSW_ST_EEPROM_BIT 2
`define SPSW_ST_STRAP_BIT 3
`define SPSW_ST_SCLK_BIT 4
// ==========================================================
// Bus responses
`define SPSW_RESP_OKAY 2'h0
`define SPSW_RESP_SLVERR 2'h2
// ==========================================================
// Timing
`define SPSW_CLK_FREQ_HZ 250000000
`define SPSW_RING_FREQ_HZ 16000
`define SPSW_RING_HALF_CYC (`SPSW_CLK_FREQ_HZ / (2 * `SPSW_RING_FREQ_HZ))
`define SPSW_STRAP_SETTLE 2'h3
`endif

/* File: logic/spsw_sync.v */
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module spsw_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Asynchronous inputs and their synchronised copies
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  // ==========================================================
  // Two stages
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // spsw_sync

/* File: verif/spsw_top_chk.sv */
// Checker on the ports of spsw_top
`timescale 1ns/1ps
`include "spsw_map.vh"
module spsw_chk (
  // Clock, reset and reset pins
  input wire clk, reset_n, global_reset_n, host_bus_reset_n,
  // Link pins
  input wire switch_clock_out, switch_clock_oe, switch_data_out,
  input wire switch_data_oe, switch_latch_out, switch_latch_oe, pme_oe,
  input wire eeprom_mode, multifunction_pin_one_oe,
  input wire multifunction_pin_four_oe,
  // Register bus
  input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [7:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_bvalid, s_axi_bready
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire any_rst = !global_reset_n || !host_bus_reset_n;
  wire [4:0] pin_oe = {switch_clock_oe, switch_data_oe, switch_latch_oe,
    multifunction_pin_one_oe, multifunction_pin_four_oe};
  sequence ring_high; switch_clock_out [*8]; endsequence
  sequence latch_high; switch_latch_out [*8]; endsequence
  chk_glob_tristate: assert property (!global_reset_n [*5] |->
    pin_oe == 5'h0 && !pme_oe) else $error("oe on in global reset");
  chk_bus_tristate: assert property (!host_bus_reset_n [*5] |->
    pin_oe == 5'h0) else $error("oe on in bus reset");
  chk_ring_half: assert property (disable iff (!reset_n || any_rst)
    $rose(switch_clock_out) && switch_clock_oe && $past(switch_clock_oe)
    |-> ring_high ##1 !switch_clock_out) else $error("ring half wrong");
  chk_data_away: assert property (disable iff (!reset_n || any_rst)
    $changed(switch_data_out) && switch_clock_oe |-> !switch_clock_out)
    else $error("data moved at clock high");
  chk_latch_pulse: assert property (disable iff (!reset_n || any_rst)
    $rose(switch_latch_out) |-> latch_high ##[8:40] !switch_latch_out)
    else $error("latch pulse length wrong");
  chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h90 |=> s_axi_rvalid && s_axi_rdata == 32'h0 &&
    s_axi_rresp == `SPSW_RESP_SLVERR) else $error("unmapped read answer");
  chk_wr_answer: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid kept after bready");
  chk_rd_answer: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid kept after rready");
  chk_mf_strap: assert property (!eeprom_mode [*2] |->
    !multifunction_pin_one_oe && !multifunction_pin_four_oe)
    else $error("mf pins driven outside eeprom mode");
endmodule // spsw_chk
bind spsw_top spsw_chk spsw_chk_inst (.*);

/* File: verif/spsw_switch_model.sv */
// Behavioural model of the external power switch and latch strap
`timescale 1ns/1ps
module spsw_switch_model (
  // Bench controls
  input wire ext_run, strap_low,
  // Pins from the block
  input wire switch_clock_out, switch_clock_oe, switch_data_out,
  input wire switch_data_oe, switch_latch_out, switch_latch_oe,
  // Pins to the block
  output reg switch_clock_in,
  output wire switch_latch_in,
  // Observed frame
  output reg [7:0] applied,
  output integer nlatch
);
  // ==========================================================
  // Wire levels
  reg [7:0] shift = 8'h00;
  wire sclk = switch_clock_oe ? switch_clock_out : switch_clock_in;
  wire sdat = switch_data_oe ? switch_data_out : ~switch_data_out;
  assign switch_latch_in = switch_latch_oe ? switch_latch_out : !strap_low;
  // ==========================================================
  // External clock, 64 ns, held low while ext_run is low
  initial begin
    switch_clock_in = 1'b0;
    applied = 8'h00;
    nlatch = 0;
    #13.3;
    forever begin
      #32;
      switch_clock_in = ext_run ? ~switch_clock_in : 1'b0;
    end
  end
  always @(posedge sclk) shift <= {shift[6:0], sdat};
  always @(posedge switch_latch_in) begin
    if (switch_latch_oe) begin
      applied <= shift;
      nlatch <= nlatch + 1;
    end
  end
endmodule // spsw_switch_model

/* File: verif/spsw_top_bench.sv */
// Testbench of spsw_top
`timescale 1ns/1ps
`include "spsw_map.vh"
module spsw_top_bench;
  // ==========================================================
  // Stimulus and wires
  reg clk = 1'b0, reset_n = 1'b0, global_reset_n = 1'b0;
  reg host_bus_reset_n = 1'b0, suspend = 1'b0, ext_run = 1'b0;
  reg strap_low = 1'b0, pme_event = 1'b0, eeprom_scl = 1'b0;
  reg eeprom_sda_out = 1'b0, eeprom_sda_oe = 1'b0;
  reg multifunction_pin_one_in = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire switch_clock_in, switch_clock_out, switch_clock_oe;
  wire switch_data_out, switch_data_oe, switch_latch_in;
  wire switch_latch_out, switch_latch_oe, eeprom_sda_in, eeprom_mode;
  wire multifunction_pin_one_out, multifunction_pin_one_oe;
  wire multifunction_pin_four_out, multifunction_pin_four_oe;
  wire pme_out, pme_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] applied;
  integer nlatch, errors = 0, checks = 0;
  wire [5:0] all_oe = {switch_clock_oe, switch_data_oe, switch_latch_oe,
    multifunction_pin_one_oe, multifunction_pin_four_oe, pme_oe};
  spsw_top #(.FRAME_BITS(8), .RING_HALF(8)) spsw_top_inst (.*);
  spsw_switch_model spsw_switch_model_inst (.ext_run(ext_run),
    .strap_low(strap_low), .switch_clock_out(switch_clock_out),
    .switch_clock_oe(switch_clock_oe), .switch_data_out(switch_data_out),
    .switch_data_oe(switch_data_oe), .switch_latch_out(switch_latch_out),
    .switch_latch_oe(switch_latch_oe), .switch_clock_in(switch_clock_in),
    .switch_latch_in(switch_latch_in), .applied(applied), .nlatch(nlatch));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task check(input [31:0] e, input [31:0] g, input [8*8:1] w);
    begin
      checks = checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", w, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(er, s_axi_bresp, "bresp");
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(e, s_axi_rdata, "rdata");
      check(er, s_axi_rresp, "rresp");
    end
  endtask
  task hit_reset(input g, input b, input s);
    begin
      @(posedge clk);
      suspend <= s;
      global_reset_n <= !g;
      host_bus_reset_n <= !b;
      tick(8);
    end
  endtask
  task free_reset;
    begin
      global_reset_n <= 1'b1;
      host_bus_reset_n <= 1'b1;
      tick(12);
      suspend <= 1'b0;
      tick(4);
    end
  endtask
  task wait_latch(input [31:0] e);
    integer k;
    begin
      k = nlatch;
      while (nlatch == k) @(posedge clk);
      check(e, applied, "frame");
      while (switch_latch_out !== 1'b0) @(posedge clk);
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_frames;
    begin
      rd(8'h84, 32'h0, `SPSW_RESP_OKAY);
      rd(8'h90, 32'h0, `SPSW_RESP_SLVERR);
      wr(8'h90, 32'h1, `SPSW_RESP_SLVERR);
      check(1'b0, switch_clock_oe, "clk_oe");
      wr(8'h80, 32'h08000000, `SPSW_RESP_OKAY);
      rd(8'h80, 32'h08000000, `SPSW_RESP_OKAY);
      check(1'b1, switch_clock_oe, "clk_oe");
      wr(8'h84, 32'ha5, `SPSW_RESP_OKAY);
      wait_latch(32'ha5);
      wr(8'h80, 32'h0, `SPSW_RESP_OKAY);
      tick(4);
      check(1'b0, switch_clock_oe, "clk_oe");
      ext_run <= 1'b1;
      wr(8'h84, 32'h3c, `SPSW_RESP_OKAY);
      wait_latch(32'h3c);
      ext_run <= 1'b0;
    end
  endtask
  task t_resets;
    begin
      wr(8'h80, 32'h08000100, `SPSW_RESP_OKAY);
      hit_reset(1'b1, 1'b0, 1'b1);
      check(6'h0, all_oe, "oe");
      free_reset;
      rd(8'h80, 32'h08000100, `SPSW_RESP_OKAY);
      hit_reset(1'b0, 1'b1, 1'b1);
      check(6'h0, all_oe, "oe");
      free_reset;
      rd(8'h80, 32'h08000100, `SPSW_RESP_OKAY);
      pme_event <= 1'b1;
      hit_reset(1'b0, 1'b1, 1'b0);
      check(6'h1, all_oe, "oe");
      free_reset;
      rd(8'h80, 32'h00000100, `SPSW_RESP_OKAY);
      wr(8'h80, 32'h08000100, `SPSW_RESP_OKAY);
      hit_reset(1'b1, 1'b0, 1'b0);
      check(6'h0, all_oe, "oe");
      free_reset;
      pme_event <= 1'b0;
      rd(8'h80, 32'h0, `SPSW_RESP_OKAY);
      rd(8'h84, 32'h0, `SPSW_RESP_OKAY);
    end
  endtask
  task t_strap;
    begin
      strap_low <= 1'b1;
      hit_reset(1'b1, 1'b1, 1'b0);
      free_reset;
      check(1'b1, eeprom_mode, "eeprom");
      eeprom_scl <= 1'b1;
      eeprom_sda_oe <= 1'b1;
      tick(3);
      check(2'h3, {multifunction_pin_four_out, multifunction_pin_one_oe},
        "mf_pins");
      check(3'h4, {eeprom_sda_in, multifunction_pin_one_out, pme_out},
        "mf_more");
      rd(8'h88, 32'hc, `SPSW_RESP_OKAY);
      strap_low <= 1'b0;
      eeprom_scl <= 1'b0;
      eeprom_sda_oe <= 1'b0;
      hit_reset(1'b1, 1'b1, 1'b0);
      free_reset;
      check(1'b0, eeprom_mode, "eeprom");
    end
  endtask
  // ==========================================================
  // Run control
  task stop_test;
    begin
      $display("Checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #40000;
    errors = errors + 1;
    stop_test;
  end
  initial begin
    tick(5);
    reset_n <= 1'b1;
    tick(2);
    free_reset;
    t_frames;
    t_resets;
    t_strap;
    stop_test;
  end
endmodule // spsw_top_bench
